// ==== i2m_line_watch.sv ====
// line synchroniser and start/stop condition detector
`timescale 1ns/1ns
`default_nettype none
module i2m_line_watch (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda,
   output logic o_start,
   output logic o_stop
);
   logic [1:0] meta_reg, meta_next;
   logic [1:0] sync_reg, sync_next;
   logic [1:0] prev_reg, prev_next;

   // bit 1 is the clock line, bit 0 the data line
   always_comb begin
      meta_next = {i_scl, i_sda};
      sync_next = meta_reg;
      prev_next = sync_reg;
   end

   // first stage feeds only the second stage
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta_reg <= 2'h3;
         sync_reg <= 2'h3;
         prev_reg <= 2'h3;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         prev_reg <= prev_next;
      end
   end

   // data edge while clock stays high marks a condition
   assign o_scl = sync_reg[1];
   assign o_sda = sync_reg[0];
   assign o_start = prev_reg[1] && sync_reg[1] && prev_reg[0] && !sync_reg[0];
   assign o_stop = prev_reg[1] && sync_reg[1] && !prev_reg[0] && sync_reg[0];
endmodule
`default_nettype wire

// ==== i2m_master.sv ====
// two-wire master port with status register, apb slave and interrupt
// What this block does
// - bit 4 shows stop seen last, bit 3 shows start seen last
// - stop-seen and start-seen flags clear on reset or port off
// - bit 2 holds the direction of the last address, until start/stop/nack
// - in master mode bit 2 shows a transmission in progress
// - bit 0 shows the buffer holds an unconsumed byte, ack excluded on receive, included on transmit
// - master hardware drives both lines when the pin direction bits say input
// - six actions: start, restart, send byte, receive, send ack, stop
// - no queueing: buffer write while busy is dropped and flags collision
// - event flag set on start, stop, restart, byte done, ack sent
// - buffer write during a restart keeps the buffer and flags collision
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module i2m_master #(
   parameter int DIV_W = 8
) (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   input wire logic I_SCL,
   input wire logic I_SDA,
   input wire logic I_SCL_DIR_IN,
   input wire logic I_SDA_DIR_IN,
   output logic O_SCL,
   output logic O_SCL_OE,
   output logic O_SDA,
   output logic O_SDA_OE,
   output logic O_SLEW_LIMIT_EN,
   output logic O_SMBUS_THRESH_EN,
   output logic O_IRQ
);
   if (DIV_W < 2 || DIV_W > 8) begin : g_chk
      $error("DIV_W must lie between 2 and 8");
   end

   logic scl_s, sda_s, start_det, stop_det;
   i2m_line_watch u_watch (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_scl(I_SCL),
      .i_sda(I_SDA),
      .o_scl(scl_s),
      .o_sda(sda_s),
      .o_start(start_det),
      .o_stop(stop_det)
   );

   i2m_pkg::i2m_state_t state_reg, state_next;
   logic slew_reg, slew_next, smb_reg, smb_next, da_reg, da_next;
   logic stop_seen_reg, stop_seen_next, start_seen_reg, start_seen_next;
   logic rw_reg, rw_next, bf_reg, bf_next, write_collision_flag_reg, write_collision_flag_next;
   logic port_on_reg, port_on_next, tx_reg, tx_next;
   logic ackdt_reg, ackdt_next, ackstat_reg, ackstat_next, addr_ph_reg, addr_ph_next;
   logic scl_low_reg, scl_low_next, sda_low_reg, sda_low_next;
   logic [3:0] mode_reg, mode_next, bitcnt_reg, bitcnt_next;
   logic [i2m_pkg::REQ_W-1:0] req_reg, req_next;
   logic [i2m_pkg::EV_W-1:0] evt_reg, evt_next, mask_reg, mask_next, ev;
   logic [8:0] shift_reg, shift_next;
   logic [7:0] rx_reg, rx_next, status_word;
   logic [DIV_W-1:0] baud_reg, baud_next, cnt_reg, cnt_next;
   logic [31:0] prdata_reg, prdata_next;
   logic apb_wr, apb_rd, master_on, hw_drive, busy, run, tick, hi_phase;

   // known offsets only; anything else answers with an error
   function automatic logic addr_ok(input logic [7:0] a);
      return a == i2m_pkg::ADDR_STATUS || a == i2m_pkg::ADDR_CTRL1 || a == i2m_pkg::ADDR_CTRL2 ||
             a == i2m_pkg::ADDR_BUF || a == i2m_pkg::ADDR_BAUD || a == i2m_pkg::ADDR_EVT ||
             a == i2m_pkg::ADDR_MASK;
   endfunction

   // bus strobes and mode decode
   assign apb_wr = I_PSEL && I_PENABLE && I_PWRITE && addr_ok(I_PADDR);
   assign apb_rd = I_PSEL && I_PENABLE && !I_PWRITE && addr_ok(I_PADDR);
   assign master_on = port_on_reg && (mode_reg == i2m_pkg::MODE_MASTER);
   assign hw_drive = master_on && I_SCL_DIR_IN && I_SDA_DIR_IN;
   // pending request or running sequence both count as busy
   assign busy = (state_reg != i2m_pkg::S_IDLE) || (|req_reg);
   assign hi_phase = state_reg == i2m_pkg::S_BIT_HI || state_reg == i2m_pkg::S_ACK_HI ||
                     state_reg == i2m_pkg::S_RS_HI || state_reg == i2m_pkg::S_STOP_HI;
   // a slave stretching the clock holds the high phase timer
   assign run = !(hi_phase && !scl_s);
   assign tick = run && (cnt_reg == '0) && (state_reg != i2m_pkg::S_IDLE);
   assign status_word = {slew_reg, smb_reg, da_reg, stop_seen_reg, start_seen_reg,
                         master_on ? tx_reg : rw_reg, 1'b0, bf_reg};

   // register file, condition flags and master sequencer
   always_comb begin
      state_next = state_reg;
      slew_next = slew_reg;
      smb_next = smb_reg;
      da_next = da_reg;
      stop_seen_next = stop_seen_reg;
      start_seen_next = start_seen_reg;
      rw_next = rw_reg;
      bf_next = bf_reg;
      write_collision_flag_next = write_collision_flag_reg;
      port_on_next = port_on_reg;
      tx_next = tx_reg;
      ackdt_next = ackdt_reg;
      ackstat_next = ackstat_reg;
      addr_ph_next = addr_ph_reg;
      scl_low_next = scl_low_reg;
      sda_low_next = sda_low_reg;
      mode_next = mode_reg;
      bitcnt_next = bitcnt_reg;
      req_next = req_reg;
      mask_next = mask_reg;
      shift_next = shift_reg;
      rx_next = rx_reg;
      baud_next = baud_reg;
      ev = '0;
      prdata_next = prdata_reg;
      // software writes; write_collision_flag is cleared by writing 0, set below wins
      if (apb_wr) begin
         case (I_PADDR)
            i2m_pkg::ADDR_STATUS: begin
               slew_next = I_PWDATA[i2m_pkg::ST_SLEW];
               smb_next = I_PWDATA[i2m_pkg::ST_SMB];
            end
            i2m_pkg::ADDR_CTRL1: begin
               if (!I_PWDATA[i2m_pkg::C1_WRITE_COLLISION_FLAG]) begin
                  write_collision_flag_next = 1'b0;
               end
               port_on_next = I_PWDATA[i2m_pkg::C1_PORT_ON];
               mode_next = I_PWDATA[i2m_pkg::C1_MODE_LSB +: i2m_pkg::MODE_W];
            end
            i2m_pkg::ADDR_CTRL2: begin
               ackdt_next = I_PWDATA[i2m_pkg::C2_ACKDT];
               // requests are taken only when nothing is running
               if (master_on && !busy) begin
                  req_next = I_PWDATA[i2m_pkg::REQ_W-1:0];
               end
            end
            i2m_pkg::ADDR_BUF: begin
               if (busy || !master_on) begin
                  write_collision_flag_next = 1'b1;
               end else begin
                  shift_next = {I_PWDATA[7:0], 1'b1};
                  bitcnt_next = i2m_pkg::TX_BITS;
                  tx_next = 1'b1;
                  bf_next = 1'b1;
                  state_next = i2m_pkg::S_BIT_LO;
                  if (addr_ph_reg) begin
                     rw_next = I_PWDATA[0];
                  end
               end
            end
            i2m_pkg::ADDR_BAUD: baud_next = I_PWDATA[DIV_W-1:0];
            i2m_pkg::ADDR_MASK: mask_next = I_PWDATA[i2m_pkg::EV_W-1:0];
            default: begin
            end
         endcase
      end
      // reading the received byte consumes it
      if (apb_rd && I_PADDR == i2m_pkg::ADDR_BUF) begin
         bf_next = 1'b0;
      end
      // sequencer; the clock line stays low between events until a stop releases it
      case (state_reg)
         i2m_pkg::S_IDLE: begin
            if (master_on) begin
               if (req_reg[i2m_pkg::C2_SEN]) begin
                  state_next = i2m_pkg::S_START;
               end else if (req_reg[i2m_pkg::C2_RESTART_REQUEST]) begin
                  state_next = i2m_pkg::S_RS_LO;
               end else if (req_reg[i2m_pkg::C2_PEN]) begin
                  state_next = i2m_pkg::S_STOP_LO;
               end else if (req_reg[i2m_pkg::C2_RECEIVE_REQUEST]) begin
                  state_next = i2m_pkg::S_BIT_LO;
                  shift_next = 9'h1ff;
                  bitcnt_next = i2m_pkg::RX_BITS;
                  tx_next = 1'b0;
               end else if (req_reg[i2m_pkg::C2_ACK_SEND_REQUEST]) begin
                  state_next = i2m_pkg::S_ACK_LO;
               end
            end
         end
         i2m_pkg::S_START: begin
            sda_low_next = 1'b1;
            scl_low_next = 1'b0;
            if (tick) begin
               state_next = i2m_pkg::S_IDLE;
               scl_low_next = 1'b1;
               ev[i2m_pkg::EV_START] = 1'b1;
               req_next[i2m_pkg::C2_SEN] = 1'b0;
               addr_ph_next = 1'b1;
            end
         end
         i2m_pkg::S_RS_LO: begin
            scl_low_next = 1'b1;
            sda_low_next = 1'b0;
            if (tick) begin
               state_next = i2m_pkg::S_RS_HI;
            end
         end
         i2m_pkg::S_RS_HI: begin
            scl_low_next = 1'b0;
            if (tick) begin
               state_next = i2m_pkg::S_RS_SDA;
            end
         end
         i2m_pkg::S_RS_SDA: begin
            sda_low_next = 1'b1;
            if (tick) begin
               state_next = i2m_pkg::S_IDLE;
               scl_low_next = 1'b1;
               ev[i2m_pkg::EV_RESTART] = 1'b1;
               req_next[i2m_pkg::C2_RESTART_REQUEST] = 1'b0;
               addr_ph_next = 1'b1;
            end
         end
         i2m_pkg::S_BIT_LO: begin
            scl_low_next = 1'b1;
            sda_low_next = !shift_reg[8];
            if (tick) begin
               state_next = i2m_pkg::S_BIT_HI;
            end
         end
         i2m_pkg::S_BIT_HI: begin
            scl_low_next = 1'b0;
            if (tick) begin
               shift_next = {shift_reg[7:0], sda_s};
               bitcnt_next = bitcnt_reg - 4'h1;
               state_next = i2m_pkg::S_BIT_LO;
               if (bitcnt_reg == 4'h1) begin
                  state_next = i2m_pkg::S_IDLE;
                  scl_low_next = 1'b1;
                  ev[i2m_pkg::EV_BYTE] = 1'b1;
                  da_next = !addr_ph_reg;
                  addr_ph_next = 1'b0;
                  if (tx_reg) begin
                     ackstat_next = sda_s;
                     bf_next = 1'b0;
                     tx_next = 1'b0;
                     if (sda_s) begin
                        rw_next = 1'b0;
                     end
                  end else begin
                     rx_next = {shift_reg[6:0], sda_s};
                     bf_next = 1'b1;
                     req_next[i2m_pkg::C2_RECEIVE_REQUEST] = 1'b0;
                  end
               end
            end
         end
         i2m_pkg::S_ACK_LO: begin
            scl_low_next = 1'b1;
            sda_low_next = !ackdt_reg;
            if (tick) begin
               state_next = i2m_pkg::S_ACK_HI;
            end
         end
         i2m_pkg::S_ACK_HI: begin
            scl_low_next = 1'b0;
            if (tick) begin
               state_next = i2m_pkg::S_IDLE;
               scl_low_next = 1'b1;
               ev[i2m_pkg::EV_ACK] = 1'b1;
               req_next[i2m_pkg::C2_ACK_SEND_REQUEST] = 1'b0;
            end
         end
         i2m_pkg::S_STOP_LO: begin
            scl_low_next = 1'b1;
            sda_low_next = 1'b1;
            if (tick) begin
               state_next = i2m_pkg::S_STOP_HI;
            end
         end
         i2m_pkg::S_STOP_HI: begin
            scl_low_next = 1'b0;
            if (tick) begin
               state_next = i2m_pkg::S_STOP_SDA;
            end
         end
         i2m_pkg::S_STOP_SDA: begin
            sda_low_next = 1'b0;
            if (tick) begin
               state_next = i2m_pkg::S_IDLE;
               ev[i2m_pkg::EV_STOP] = 1'b1;
               req_next[i2m_pkg::C2_PEN] = 1'b0;
            end
         end
         default: state_next = i2m_pkg::S_IDLE;
      endcase
      // last condition seen on the wires wins
      if (start_det) begin
         start_seen_next = 1'b1;
         stop_seen_next = 1'b0;
         rw_next = 1'b0;
      end else if (stop_det) begin
         stop_seen_next = 1'b1;
         start_seen_next = 1'b0;
         rw_next = 1'b0;
      end
      // port off aborts everything and releases the lines
      if (!port_on_reg) begin
         start_seen_next = 1'b0;
         stop_seen_next = 1'b0;
         state_next = i2m_pkg::S_IDLE;
         req_next = '0;
         scl_low_next = 1'b0;
         sda_low_next = 1'b0;
         tx_next = 1'b0;
      end
      // read clears, but an event in the same cycle survives
      evt_next = ((apb_rd && I_PADDR == i2m_pkg::ADDR_EVT) ? '0 : evt_reg) | ev;
      // timer reloads on every state change
      if (state_next != state_reg) begin
         cnt_next = baud_reg;
      end else if (run && cnt_reg != '0) begin
         cnt_next = cnt_reg - 1'b1;
      end else begin
         cnt_next = cnt_reg;
      end
      // read data prepared in the setup cycle
      if (I_PSEL && !I_PENABLE) begin
         case (I_PADDR)
            i2m_pkg::ADDR_STATUS: prdata_next = {24'h0, status_word};
            i2m_pkg::ADDR_CTRL1: prdata_next = {24'h0, write_collision_flag_reg, 1'b0, port_on_reg, 1'b0, mode_reg};
            i2m_pkg::ADDR_CTRL2: prdata_next = {25'h0, ackstat_reg, ackdt_reg, req_reg};
            i2m_pkg::ADDR_BUF: prdata_next = {24'h0, rx_next}; // a byte landing at setup is not lost
            i2m_pkg::ADDR_BAUD: prdata_next = {{(32-DIV_W){1'b0}}, baud_reg};
            i2m_pkg::ADDR_EVT: prdata_next = {27'h0, evt_reg | ev}; // else cleared unseen at access
            i2m_pkg::ADDR_MASK: prdata_next = {27'h0, mask_reg};
            default: prdata_next = 32'h0;
         endcase
      end
   end

   // all state registered here, synchronous reset
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         state_reg <= i2m_pkg::S_IDLE;
         {slew_reg, smb_reg, da_reg, stop_seen_reg, start_seen_reg, rw_reg} <= 6'h00;
         {bf_reg, write_collision_flag_reg, port_on_reg, tx_reg, ackdt_reg, ackstat_reg} <= 6'h00;
         {addr_ph_reg, scl_low_reg, sda_low_reg} <= 3'h0;
         mode_reg <= 4'h0;
         bitcnt_reg <= 4'h0;
         req_reg <= '0;
         evt_reg <= '0;
         mask_reg <= '0;
         shift_reg <= 9'h1ff;
         rx_reg <= 8'h00;
         baud_reg <= i2m_pkg::BAUD_RESET[DIV_W-1:0];
         cnt_reg <= '0;
         prdata_reg <= 32'h0;
      end else begin
         state_reg <= state_next;
         {slew_reg, smb_reg, da_reg, stop_seen_reg, start_seen_reg, rw_reg} <=
            {slew_next, smb_next, da_next, stop_seen_next, start_seen_next, rw_next};
         {bf_reg, write_collision_flag_reg, port_on_reg, tx_reg, ackdt_reg, ackstat_reg} <=
            {bf_next, write_collision_flag_next, port_on_next, tx_next, ackdt_next, ackstat_next};
         {addr_ph_reg, scl_low_reg, sda_low_reg} <= {addr_ph_next, scl_low_next, sda_low_next};
         mode_reg <= mode_next;
         bitcnt_reg <= bitcnt_next;
         req_reg <= req_next;
         evt_reg <= evt_next;
         mask_reg <= mask_next;
         shift_reg <= shift_next;
         rx_reg <= rx_next;
         baud_reg <= baud_next;
         cnt_reg <= cnt_next;
         prdata_reg <= prdata_next;
      end
   end

   // open-drain drive: only pulls low, only with pins handed over
   assign O_SCL = 1'b0;
   assign O_SDA = 1'b0;
   assign O_SCL_OE = hw_drive && scl_low_reg;
   assign O_SDA_OE = hw_drive && sda_low_reg;
   assign O_SLEW_LIMIT_EN = !slew_reg;
   assign O_SMBUS_THRESH_EN = smb_reg;
   assign O_IRQ = |(evt_reg & mask_reg);
   assign O_PRDATA = prdata_reg;
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = I_PSEL && I_PENABLE && !addr_ok(I_PADDR);

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);

   property p_flags_off;
      !port_on_reg |=> !stop_seen_reg && !start_seen_reg;
   endproperty
   a_flags_off: assert property (p_flags_off) else $error("condition flags not cleared with port off");
   property p_start_seen;
      start_det && port_on_reg |=> start_seen_reg && !stop_seen_reg && status_word[3];
   endproperty
   a_start_seen: assert property (p_start_seen) else $error("start not reported");
   property p_stop_seen;
      stop_det && !start_det && port_on_reg |=> stop_seen_reg && !start_seen_reg && status_word[4];
   endproperty
   a_stop_seen: assert property (p_stop_seen) else $error("stop not reported");
   property p_collide;
      apb_wr && I_PADDR == i2m_pkg::ADDR_BUF && busy && state_reg != i2m_pkg::S_IDLE &&
         state_reg != i2m_pkg::S_BIT_HI |=> write_collision_flag_reg && shift_reg == $past(shift_reg);
   endproperty
   a_collide: assert property (p_collide) else $error("busy buffer write not flagged");
   property p_restart_collide;
      (state_reg == i2m_pkg::S_RS_LO || state_reg == i2m_pkg::S_RS_HI || state_reg == i2m_pkg::S_RS_SDA) &&
         apb_wr && I_PADDR == i2m_pkg::ADDR_BUF |=> write_collision_flag_reg && !tx_reg && shift_reg == $past(shift_reg);
   endproperty
   a_restart_collide: assert property (p_restart_collide) else $error("restart write not refused");
   property p_sticky;
      write_collision_flag_reg && !(apb_wr && I_PADDR == i2m_pkg::ADDR_CTRL1) |=> write_collision_flag_reg;
   endproperty
   a_sticky: assert property (p_sticky) else $error("collision flag lost");
   property p_event_irq;
      ev[i2m_pkg::EV_START] && mask_reg[i2m_pkg::EV_START] |=> evt_reg[i2m_pkg::EV_START] && O_IRQ;
   endproperty
   a_event_irq: assert property (p_event_irq) else $error("start event raised no interrupt");
   property p_rx_full;
      state_reg == i2m_pkg::S_BIT_HI && tick && bitcnt_reg == 4'h1 && !tx_reg |=> bf_reg ##0 status_word[0];
   endproperty
   a_rx_full: assert property (p_rx_full) else $error("received byte not marked full");
   property p_drive_gate;
      O_SCL_OE || O_SDA_OE |-> master_on && I_SCL_DIR_IN && I_SDA_DIR_IN;
   endproperty
   a_drive_gate: assert property (p_drive_gate) else $error("line driven outside master mode");
   property p_active;
      master_on && apb_wr && I_PADDR == i2m_pkg::ADDR_BUF && !busy |=>
         status_word[i2m_pkg::ST_RW] && status_word[i2m_pkg::ST_BF];
   endproperty
   a_active: assert property (p_active) else $error("transmit not shown active");
   property p_slew;
      apb_wr && I_PADDR == i2m_pkg::ADDR_STATUS |=> O_SLEW_LIMIT_EN == !$past(I_PWDATA[7]);
   endproperty
   a_slew: assert property (p_slew) else $error("slew control not applied");
endmodule
`default_nettype wire

// ==== i2m_master_tb.sv ====
// self-checking bench of the two-wire master port
`timescale 1ns/1ns
`default_nettype none
module i2m_master_tb;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, stop_request = 1'b0, pwr = 1'b0, perr, irq_seen = 1'b0, dir_in = 1'b1;
   logic [7:0] pa = 8'h00;
   logic [31:0] pwd = 32'h0, prd, rd;
   logic pready, slverr, scl_oe, sda_oe, slew, smb, irq, pull;
   // open-drain lines with pull-ups: released means high
   wire logic scl = ~scl_oe;
   wire logic sda = ~sda_oe & ~pull;
   int n_mismatch = 0, check_count = 0;
   always #2 clk = ~clk;
   always @(posedge clk) if (irq === 1'b1) irq_seen <= 1'b1;
   i2m_master #(.DIV_W(8)) dut (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(stop_request),
      .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(pready),
      .O_PSLVERR(slverr), .I_SCL(scl), .I_SDA(sda), .I_SCL_DIR_IN(dir_in), .I_SDA_DIR_IN(dir_in),
      .O_SCL(), .O_SCL_OE(scl_oe), .O_SDA(), .O_SDA_OE(sda_oe), .O_SLEW_LIMIT_EN(slew),
      .O_SMBUS_THRESH_EN(smb), .O_IRQ(irq));
   i2m_slave_model partner (.i_clk(clk), .i_scl(scl), .i_sda(sda), .o_pull(pull));
   task tally_and_finish;
      if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one apb transfer; holds the request until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1; stop_request <= 1'b0; pwr <= w; pa <= a; pwd <= d;
      @(posedge clk);
      stop_request <= 1'b1;
      i = 0;
      do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 50);
      if (i >= 50) begin n_mismatch++; tally_and_finish; end
      rd = prd;
      perr = slverr;
      psel <= 1'b0; stop_request <= 1'b0;
   endtask
   // read a register until a masked bit shows, bounded
   task poll(input logic [7:0] a, input logic [31:0] m);
      int i;
      i = 0;
      do begin apb(1'b0, a, 32'h0); i++; end while ((rd & m) == 32'h0 && i < 500);
      if (i >= 500) begin n_mismatch++; tally_and_finish; end
   endtask
   task t_regs;
      apb(1'b0, i2m_pkg::ADDR_STATUS, 32'h0); chk("status", rd, 32'h0);
      apb(1'b1, i2m_pkg::ADDR_STATUS, 32'hff); apb(1'b0, i2m_pkg::ADDR_STATUS, 32'h0);
      chk("status", rd, 32'hc0);
      chk("slew", slew, 32'h0);
      chk("smb", smb, 32'h1);
      apb(1'b0, 8'h40, 32'h0); chk("slverr", perr, 32'h1);
   endtask
   task t_start;
      apb(1'b1, i2m_pkg::ADDR_MASK, 32'h1f);
      apb(1'b1, i2m_pkg::ADDR_CTRL1, 32'h08); apb(1'b1, i2m_pkg::ADDR_CTRL1, 32'h28);
      apb(1'b1, i2m_pkg::ADDR_CTRL2, 32'h01); apb(1'b1, i2m_pkg::ADDR_BUF, 32'h55);
      poll(i2m_pkg::ADDR_EVT, 32'h1f);
      chk("evt", rd, 32'h01);
      apb(1'b0, i2m_pkg::ADDR_STATUS, 32'h0);
      chk("status", rd, 32'hc8);
      chk("irq", irq_seen, 32'h1);
      apb(1'b0, i2m_pkg::ADDR_CTRL1, 32'h0); apb(1'b0, i2m_pkg::ADDR_CTRL1, 32'h0);
      chk("ctrl1", rd, 32'ha8);
      apb(1'b1, i2m_pkg::ADDR_CTRL1, 32'h28);
   endtask
   task t_byte;
      apb(1'b1, i2m_pkg::ADDR_BUF, 32'ha5); apb(1'b0, i2m_pkg::ADDR_STATUS, 32'h0);
      chk("busy", rd & 32'h05, 32'h05);
      poll(i2m_pkg::ADDR_EVT, 32'h1f); chk("evt", rd, 32'h08);
      apb(1'b0, i2m_pkg::ADDR_CTRL2, 32'h0); chk("ack", rd[6], 32'h0);
      apb(1'b0, i2m_pkg::ADDR_STATUS, 32'h0); chk("idle", rd & 32'h05, 32'h0);
   endtask
   // restart with a refused write, one byte in, an ack out, then pins taken back
   task t_rx;
      apb(1'b1, i2m_pkg::ADDR_CTRL2, 32'h02);
      apb(1'b1, i2m_pkg::ADDR_BUF, 32'h3c);
      poll(i2m_pkg::ADDR_EVT, 32'h1f);
      chk("evt", rd, 32'h04);
      apb(1'b0, i2m_pkg::ADDR_CTRL1, 32'h0);
      chk("ctrl1", rd, 32'ha8);
      apb(1'b1, i2m_pkg::ADDR_CTRL1, 32'h28);
      apb(1'b1, i2m_pkg::ADDR_CTRL2, 32'h08);
      poll(i2m_pkg::ADDR_EVT, 32'h1f);
      chk("evt", rd, 32'h08);
      apb(1'b0, i2m_pkg::ADDR_STATUS, 32'h0);
      chk("full", rd & 32'h05, 32'h01);
      apb(1'b0, i2m_pkg::ADDR_BUF, 32'h0);
      chk("rx", rd, 32'hff);
      apb(1'b1, i2m_pkg::ADDR_CTRL2, 32'h10);
      poll(i2m_pkg::ADDR_EVT, 32'h1f);
      chk("evt", rd, 32'h10);
      apb(1'b0, i2m_pkg::ADDR_STATUS, 32'h0);
      chk("empty", rd & 32'h05, 32'h0);
      // both lines held low while idle; clearing the direction bits must let go
      chk("oe", {scl_oe, sda_oe}, 32'h3);
      dir_in <= 1'b0;
      @(posedge clk);
      chk("oe", {scl_oe, sda_oe}, 32'h0);
      dir_in <= 1'b1;
   endtask
   // masked stop: the event is recorded but the interrupt stays low
   task t_stop;
      apb(1'b1, i2m_pkg::ADDR_MASK, 32'h0);
      irq_seen <= 1'b0;
      apb(1'b1, i2m_pkg::ADDR_CTRL2, 32'h04);
      poll(i2m_pkg::ADDR_EVT, 32'h1f); chk("evt", rd, 32'h02);
      chk("irq", irq_seen, 32'h0);
      apb(1'b0, i2m_pkg::ADDR_STATUS, 32'h0); chk("status", rd, 32'hd0);
      apb(1'b1, i2m_pkg::ADDR_CTRL1, 32'h0); apb(1'b0, i2m_pkg::ADDR_STATUS, 32'h0);
      chk("off", rd, 32'hc0);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_start;
      t_byte;
      t_rx;
      t_stop;
      tally_and_finish;
   end
endmodule
`default_nettype wire

// ==== i2m_pkg.sv ====
// shared constants and types of the two-wire master port
package i2m_pkg;
   // register byte offsets on the apb slave
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CTRL1 = 8'h04;
   localparam logic [7:0] ADDR_CTRL2 = 8'h08;
   localparam logic [7:0] ADDR_BUF = 8'h0c;
   localparam logic [7:0] ADDR_BAUD = 8'h10;
   localparam logic [7:0] ADDR_EVT = 8'h14;
   localparam logic [7:0] ADDR_MASK = 8'h18;
   // serial_status field positions
   localparam int ST_SLEW = 7;
   localparam int ST_SMB = 6;
   localparam int ST_DA = 5;
   localparam int ST_STOP = 4;
   localparam int ST_START = 3;
   localparam int ST_RW = 2;
   localparam int ST_BF = 0;
   // serial_control_one field positions and master code
   localparam int C1_WRITE_COLLISION_FLAG = 7;
   localparam int C1_PORT_ON = 5;
   localparam int C1_MODE_LSB = 0;
   localparam int MODE_W = 4;
   localparam logic [3:0] MODE_MASTER = 4'h8;
   // second control register: request bits and ack fields
   localparam int C2_SEN = 0;
   localparam int C2_RESTART_REQUEST = 1;
   localparam int C2_PEN = 2;
   localparam int C2_RECEIVE_REQUEST = 3;
   localparam int C2_ACK_SEND_REQUEST = 4;
   localparam int C2_ACKDT = 5;
   localparam int C2_ACKSTAT = 6;
   localparam int REQ_W = 5;
   // event bits, shared by event status and mask
   localparam int EV_START = 0;
   localparam int EV_STOP = 1;
   localparam int EV_RESTART = 2;
   localparam int EV_BYTE = 3;
   localparam int EV_ACK = 4;
   localparam int EV_W = 5;
   // reset values and bit counts
   localparam logic [7:0] BAUD_RESET = 8'h09;
   localparam logic [3:0] TX_BITS = 4'h9;
   localparam logic [3:0] RX_BITS = 4'h8;
   typedef enum logic [3:0] {
      S_IDLE, S_START, S_RS_LO, S_RS_HI, S_RS_SDA, S_BIT_LO, S_BIT_HI,
      S_ACK_LO, S_ACK_HI, S_STOP_LO, S_STOP_HI, S_STOP_SDA
   } i2m_state_t;
endpackage

// ==== i2m_slave_model.sv ====
// slave on the two-wire bus that acknowledges the first byte after each start
`timescale 1ns/1ns
`default_nettype none
module i2m_slave_model (
   input wire logic i_clk,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_pull
);
   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   logic [3:0] n = 4'h0;
   initial o_pull = 1'b0;
   // count clock rises after a start, wrapping at 16; pull data low through the ninth bit and again every 16 bits after it
   always @(posedge i_clk) begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      if (scl_q && i_scl && sda_q && !i_sda) n <= 4'h0;
      else if (!scl_q && i_scl) n <= n + 4'h1;
      if (scl_q && !i_scl) o_pull <= (n == 4'h8);
   end
endmodule
`default_nettype wire
